// [thermal_one_wire_poller.sv]
// thermal single-wire poller: APB registers, frame engine, bridge
// assumes synchronous pin inputs and an external pull-down on both wires
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps

// Contract
// - one self-clocked wire, rates from 2 kbps to 2 Mbps
// - domain-count bit set polls domains 0 and 1, else only 0
// - domain-select bit picks domain 1 or domain 0 for reading
// - E5 bit 1 set reports the higher of the two domains
// - agent enables in E0h 7..4 clear at reset; disabled agents untouched
// - enabled agents get probe and read-temperature commands repeatedly
// - raw relative reading readable at FEh and FFh
// - reported temperature is base plus signed relative reading
// - 49h bits 2..0 and 6..4 choose sources of both readings
// - two reading registers, each a high and low index pair
// - E5h bit 0 bridges secondary pin to the client wire
// - per-agent warning flag in E8h bits 7..4
// - reading holds integer degrees high, half degree at low bit 7; here the low byte always reads 0
module thermal_one_wire_poller
  import poller_pkg::*;
#(
  parameter int QTR_SLOW_CYC = QTR_0_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_in,
  output logic link_out,
  output logic link_oe,
  input wire logic secondary_link_pin_in,
  output logic secondary_link_pin_out,
  output logic secondary_link_pin_oe,
  output logic [8:0] first_temp_reading,
  output logic [8:0] second_temp_reading,
  output logic irq
);

  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    c = crc ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic signed [7:0] smax(input logic [7:0] a, input logic [7:0] b);
    return ($signed(a) > $signed(b)) ? a : b;
  endfunction

  logic [7:0] src_sel_reg, en_dsel_reg, dcnt_reg, rd1_reg, rd2_reg;
  logic [7:0] crc_reg, rx_shift_reg, d0_reg;
  logic [7:0] base_reg [4], dom0_reg [4], dom1_reg [4];
  logic [1:0] speed_reg, ag_reg, phase_reg;
  logic [1:0] fail_reg [4];
  logic [2:0] bit_reg, byte_reg;
  logic [15:0] raw_reg;
  logic [3:0] warn_reg;
  logic [STAT_W-1:0] status_reg, mask_reg;
  logic [31:0] prdata_reg;
  logic [QW-1:0] q_cnt_reg;
  logic pslverr_reg, frame_ok_reg, drive_reg, level_reg;
  link_state_t state_reg;
  poll_step_t step_reg;
  bridge_own_t own_reg;

  // apb slave, zero wait states
  logic [7:0] idx;
  logic wr_en, rd_access, setup, mapped;
  logic [31:0] rd_val;

  assign idx = paddr[9:2];
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & mapped;
  assign rd_access = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (idx)
      IDX_SRC_SEL: rd_val[7:0] = src_sel_reg;
      IDX_RD1_HI: rd_val[7:0] = rd1_reg;
      IDX_RD1_LO: rd_val[7:0] = 8'h00;
      IDX_RD2_HI: rd_val[7:0] = rd2_reg;
      IDX_RD2_LO: rd_val[7:0] = 8'h00;
      IDX_EN_DSEL: rd_val[7:0] = en_dsel_reg;
      IDX_DCNT: rd_val[7:0] = dcnt_reg;
      IDX_SPEED: rd_val[7:0] = {warn_reg, 2'b00, speed_reg};
      IDX_STATUS: rd_val[STAT_W-1:0] = status_reg;
      IDX_MASK: rd_val[STAT_W-1:0] = mask_reg;
      IDX_RAW_LO: rd_val[7:0] = raw_reg[7:0];
      IDX_RAW_HI: rd_val[7:0] = raw_reg[15:8];
      default: begin
        if (idx >= IDX_BASE1 && idx <= IDX_BASE4) begin
          rd_val[7:0] = base_reg[2'(idx - IDX_BASE1)];
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  // answer is prepared in the setup cycle so it comes from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr_reg <= ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_sel_reg <= 8'h00;
      en_dsel_reg <= 8'h00;
      dcnt_reg <= 8'h00;
      speed_reg <= 2'b00;
      mask_reg <= '0;
      for (int i = 0; i < 4; i++) begin
        base_reg[i] <= 8'h00;
      end
    end else if (wr_en) begin
      unique case (idx)
        IDX_SRC_SEL: src_sel_reg <= pwdata[7:0];
        IDX_EN_DSEL: en_dsel_reg <= pwdata[7:0];
        IDX_DCNT: dcnt_reg <= pwdata[7:0];
        IDX_SPEED: speed_reg <= pwdata[1:0];
        IDX_MASK: mask_reg <= pwdata[STAT_W-1:0];
        default: begin
          if (idx >= IDX_BASE1 && idx <= IDX_BASE4) begin
            base_reg[2'(idx - IDX_BASE1)] <= pwdata[7:0];
          end
        end
      endcase
    end
  end

  // quarter-slot divider
  logic [QW-1:0] q_len;
  logic q_tick;

  always_comb begin
    unique case (speed_reg)
      2'b00: q_len = QW'(QTR_SLOW_CYC);
      2'b01: q_len = QW'(QTR_1_CYC);
      2'b10: q_len = QW'(QTR_2_CYC);
      2'b11: q_len = QW'(QTR_3_CYC);
    endcase
  end

  assign q_tick = (state_reg != ST_IDLE) && (q_cnt_reg >= q_len - QW'(1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_cnt_reg <= '0;
    end else if (state_reg == ST_IDLE || q_tick) begin
      q_cnt_reg <= '0;
    end else begin
      q_cnt_reg <= q_cnt_reg + QW'(1);
    end
  end

  // frame engine
  logic [3:0] enables;
  logic bridge_on, bit_end, byte_end, tx_bit;
  logic [7:0] tx_val;

  assign enables = en_dsel_reg[F_HI4 +: 4];
  assign bridge_on = dcnt_reg[F_BRIDGE] && state_reg == ST_IDLE;
  assign bit_end = q_tick && phase_reg == 2'b11;
  assign byte_end = bit_end && bit_reg == 3'h7;

  always_comb begin
    unique case (byte_reg)
      3'h0: tx_val = AGENT_ADDR0 + {6'h00, ag_reg};
      3'h1: tx_val = (step_reg == STEP_PROBE) ? CMD_PROBE : CMD_READ_TEMP;
      3'h2: tx_val = {7'h00, step_reg == STEP_DOM1};
      default: tx_val = crc_reg;
    endcase
  end

  assign tx_bit = tx_val[3'h7 - bit_reg];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      phase_reg <= 2'b00;
      bit_reg <= 3'h0;
      byte_reg <= 3'h0;
      crc_reg <= CRC_INIT;
      rx_shift_reg <= 8'h00;
      d0_reg <= 8'h00;
      frame_ok_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          phase_reg <= 2'b00;
          bit_reg <= 3'h0;
          byte_reg <= 3'h0;
          crc_reg <= CRC_INIT;
          // a disabled agent is skipped by the scheduler
          if (!dcnt_reg[F_BRIDGE] && enables[ag_reg]) begin
            state_reg <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (q_tick) begin
            phase_reg <= phase_reg + 2'b01;
          end
          if (bit_end) begin
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == GAP_BITS - 3'h1) begin
              bit_reg <= 3'h0;
              state_reg <= ST_TX;
            end
          end
        end
        ST_TX: begin
          if (q_tick) begin
            phase_reg <= phase_reg + 2'b01;
          end
          if (bit_end) begin
            bit_reg <= bit_reg + 3'h1;
          end
          if (byte_end) begin
            byte_reg <= byte_reg + 3'h1;
            if (byte_reg == BYTE_FCS_TX) begin
              crc_reg <= CRC_INIT;
              state_reg <= ST_RX;
            end else begin
              crc_reg <= crc8(crc_reg, tx_val);
            end
          end
        end
        ST_RX: begin
          if (q_tick) begin
            phase_reg <= phase_reg + 2'b01;
          end
          // sample in the middle of the bit, after the client had time to extend
          if (q_tick && phase_reg == 2'b01) begin
            rx_shift_reg <= {rx_shift_reg[6:0], link_in};
          end
          if (bit_end) begin
            bit_reg <= bit_reg + 3'h1;
          end
          if (byte_end) begin
            byte_reg <= byte_reg + 3'h1;
            if (byte_reg == BYTE_D0) begin
              d0_reg <= rx_shift_reg;
            end
            if (byte_reg == BYTE_FCS_RX) begin
              frame_ok_reg <= rx_shift_reg == crc_reg;
              state_reg <= ST_DONE;
            end else begin
              crc_reg <= crc8(crc_reg, rx_shift_reg);
            end
          end
        end
        ST_DONE: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // by DONE rx_shift_reg has moved on to the check byte
  logic [7:0] d1_keep_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d1_keep_reg <= 8'h00;
    end else if (state_reg == ST_RX && byte_end && byte_reg == BYTE_D1) begin
      d1_keep_reg <= rx_shift_reg;
    end
  end

  // poll scheduler and results
  logic done;
  logic [7:0] new_temp;

  assign done = state_reg == ST_DONE;
  assign new_temp = base_reg[ag_reg] + {d1_keep_reg[5:0], d0_reg[7:6]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ag_reg <= 2'b00;
      step_reg <= STEP_PROBE;
    end else if (state_reg == ST_IDLE && !dcnt_reg[F_BRIDGE] && !enables[ag_reg]) begin
      ag_reg <= ag_reg + 2'b01;
      step_reg <= STEP_PROBE;
    end else if (done) begin
      unique case (step_reg)
        STEP_PROBE: begin
          step_reg <= frame_ok_reg ? STEP_DOM0 : STEP_PROBE;
          ag_reg <= frame_ok_reg ? ag_reg : ag_reg + 2'b01;
        end
        STEP_DOM0: begin
          if (frame_ok_reg && dcnt_reg[F_HI4 + ag_reg]) begin
            step_reg <= STEP_DOM1;
          end else begin
            step_reg <= STEP_PROBE;
            ag_reg <= ag_reg + 2'b01;
          end
        end
        default: begin
          step_reg <= STEP_PROBE;
          ag_reg <= ag_reg + 2'b01;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_reg <= 16'h0000;
      for (int i = 0; i < 4; i++) begin
        dom0_reg[i] <= 8'h00;
        dom1_reg[i] <= 8'h00;
      end
    end else if (done && frame_ok_reg && step_reg != STEP_PROBE) begin
      raw_reg <= {d1_keep_reg, d0_reg};
      if (step_reg == STEP_DOM1) begin
        dom1_reg[ag_reg] <= new_temp;
      end else begin
        dom0_reg[ag_reg] <= new_temp;
      end
    end
  end

  // three failed frames in a row raise the flag; any good frame drops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_reg <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        fail_reg[i] <= 2'b00;
      end
    end else if (done) begin
      if (frame_ok_reg) begin
        fail_reg[ag_reg] <= 2'b00;
        warn_reg[ag_reg] <= 1'b0;
      end else if (fail_reg[ag_reg] != FAIL_LIMIT) begin
        fail_reg[ag_reg] <= fail_reg[ag_reg] + 2'b01;
        if (fail_reg[ag_reg] == FAIL_LIMIT - 2'b01) begin
          warn_reg[ag_reg] <= 1'b1;
        end
      end
    end
  end

  // reading registers
  function automatic logic [7:0] agent_temp(input logic [1:0] a);
    if (dcnt_reg[F_MAXDOM]) begin
      return smax(dom0_reg[a], dom1_reg[a]);
    end
    return en_dsel_reg[a] ? dom1_reg[a] : dom0_reg[a];
  endfunction

  // codes 0..3 are sensors outside this block and read zero
  function automatic logic [7:0] src_temp(input logic [2:0] code);
    return (code >= SRC_AGENT1) ? agent_temp(2'(code - SRC_AGENT1)) : 8'h00;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd1_reg <= 8'h00;
      rd2_reg <= 8'h00;
    end else begin
      rd1_reg <= src_temp(src_sel_reg[2:0]);
      rd2_reg <= src_temp(src_sel_reg[F_SRC2 +: 3]);
    end
  end

  assign first_temp_reading = {rd1_reg, 1'b0};
  assign second_temp_reading = {rd2_reg, 1'b0};

  // interrupts, read clears, a new event wins
  logic [3:0] warn_prev_reg;
  logic [STAT_W-1:0] events;
  logic stat_read;

  assign events = {done && frame_ok_reg && step_reg != STEP_PROBE, warn_reg & ~warn_prev_reg};
  assign stat_read = rd_access && idx == IDX_STATUS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_prev_reg <= 4'h0;
      status_reg <= '0;
    end else begin
      warn_prev_reg <= warn_reg;
      status_reg <= (stat_read ? '0 : status_reg) | events;
    end
  end

  assign irq = |(status_reg & mask_reg);

  // pin drive and bridge
  logic drive_next, level_next;

  always_comb begin
    drive_next = 1'b0;
    level_next = 1'b0;
    unique case (state_reg)
      ST_TX: begin
        drive_next = 1'b1;
        level_next = phase_reg == 2'b00 || (tx_bit && phase_reg != 2'b11);
      end
      ST_RX: begin
        drive_next = phase_reg == 2'b00;
        level_next = 1'b1;
      end
      default: begin
        drive_next = own_reg == OWN_SEC;
        level_next = own_reg == OWN_SEC;
      end
    endcase
  end

  // our own drive echoes on link_in for a cycle; it must not claim the link side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_reg <= OWN_NONE;
    end else if (!bridge_on) begin
      own_reg <= OWN_NONE;
    end else begin
      unique case (own_reg)
        OWN_NONE: begin
          if (secondary_link_pin_in) begin
            own_reg <= OWN_SEC;
          end else if (link_in && !drive_reg) begin
            own_reg <= OWN_LINK;
          end
        end
        OWN_SEC: own_reg <= secondary_link_pin_in ? OWN_SEC : OWN_NONE;
        OWN_LINK: own_reg <= link_in ? OWN_LINK : OWN_NONE;
        default: own_reg <= OWN_NONE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      drive_reg <= drive_next;
      level_reg <= level_next;
    end
  end

  assign link_oe = drive_reg;
  assign link_out = level_reg;
  assign secondary_link_pin_oe = own_reg == OWN_LINK;
  assign secondary_link_pin_out = own_reg == OWN_LINK;

endmodule // thermal_one_wire_poller

// [poller_pkg.sv]
// constants shared by the thermal single-wire poller
// assumes a 200 MHz pclk and an APB master with 32-bit data
package poller_pkg;
  localparam int CLK_HZ = 200_000_000;
  // link bit rates per speed code, bits per second
  localparam int RATE_0_BPS = 2_000;
  localparam int RATE_1_BPS = 20_000;
  localparam int RATE_2_BPS = 200_000;
  localparam int RATE_3_BPS = 2_000_000;
  // four quarter slots per bit; a longest time rounds down
  localparam int QTR_0_CYC = CLK_HZ / (RATE_0_BPS * 4);
  localparam int QTR_1_CYC = CLK_HZ / (RATE_1_BPS * 4);
  localparam int QTR_2_CYC = CLK_HZ / (RATE_2_BPS * 4);
  localparam int QTR_3_CYC = CLK_HZ / (RATE_3_BPS * 4);
  localparam int QW = 17;
  localparam logic [2:0] GAP_BITS = 3'h2;
  localparam logic [1:0] FAIL_LIMIT = 2'h3;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_SRC_SEL = 8'h49;
  localparam logic [7:0] IDX_RD1_HI = 8'h50;
  localparam logic [7:0] IDX_RD1_LO = 8'h51;
  localparam logic [7:0] IDX_RD2_HI = 8'h52;
  localparam logic [7:0] IDX_RD2_LO = 8'h53;
  localparam logic [7:0] IDX_EN_DSEL = 8'hE0;
  localparam logic [7:0] IDX_BASE1 = 8'hE1;
  localparam logic [7:0] IDX_BASE4 = 8'hE4;
  localparam logic [7:0] IDX_DCNT = 8'hE5;
  localparam logic [7:0] IDX_SPEED = 8'hE8;
  localparam logic [7:0] IDX_STATUS = 8'hF0;
  localparam logic [7:0] IDX_MASK = 8'hF1;
  localparam logic [7:0] IDX_RAW_LO = 8'hFE;
  localparam logic [7:0] IDX_RAW_HI = 8'hFF;
  // field positions
  localparam int F_BRIDGE = 0;
  localparam int F_MAXDOM = 1;
  localparam int F_HI4 = 4;
  localparam int F_SRC2 = 4;
  localparam logic [2:0] SRC_AGENT1 = 3'h4;
  // frame contents
  localparam logic [7:0] AGENT_ADDR0 = 8'h30;
  localparam logic [7:0] CMD_PROBE = 8'h00;
  localparam logic [7:0] CMD_READ_TEMP = 8'h01;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [2:0] BYTE_FCS_TX = 3'h3;
  localparam logic [2:0] BYTE_D0 = 3'h4;
  localparam logic [2:0] BYTE_D1 = 3'h5;
  localparam logic [2:0] BYTE_FCS_RX = 3'h6;
  localparam int STAT_W = 5;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_GAP = 3'b001,
    ST_TX = 3'b010,
    ST_RX = 3'b011,
    ST_DONE = 3'b100
  } link_state_t;

  typedef enum logic [1:0] {
    STEP_PROBE = 2'b00,
    STEP_DOM0 = 2'b01,
    STEP_DOM1 = 2'b10
  } poll_step_t;

  typedef enum logic [1:0] {
    OWN_NONE = 2'b00,
    OWN_SEC = 2'b01,
    OWN_LINK = 2'b10
  } bridge_own_t;
endpackage

// [poller_checker.sv]
// port assertions for the thermal single-wire poller
// assumes register writes are seen only through the apb ports
`timescale 1ns/1ps
module poller_checker
  import poller_pkg::*;
#(
  parameter int QTR_SLOW_CYC = QTR_0_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic link_in,
  input wire logic link_out,
  input wire logic link_oe,
  input wire logic secondary_link_pin_in,
  input wire logic secondary_link_pin_out,
  input wire logic secondary_link_pin_oe,
  input wire logic [8:0] first_temp_reading,
  input wire logic [8:0] second_temp_reading,
  input wire logic irq
);
  // a frame is under 256 quarter slots, so a longer silence means the engine is idle
  localparam int QUIET = 256 * QTR_SLOW_CYC;
  logic [7:0] idx_w;
  logic wr, map_ok, brg_reg, src_reg;
  logic [3:0] en_reg;
  logic [1:0] spd_reg;
  logic [4:0] mask_reg;
  logic [15:0] quiet_reg;
  assign idx_w = paddr[9:2];
  assign wr = psel & penable & pwrite;
  assign map_ok = idx_w == IDX_SRC_SEL || (idx_w >= IDX_RD1_HI && idx_w <= IDX_RD2_LO) ||
    (idx_w >= IDX_EN_DSEL && idx_w <= IDX_DCNT) || idx_w == IDX_SPEED ||
    idx_w == IDX_STATUS || idx_w == IDX_MASK || idx_w >= IDX_RAW_LO;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= 4'h0;
      brg_reg <= 1'b0;
      spd_reg <= 2'h0;
      mask_reg <= 5'h00;
      src_reg <= 1'b0;
    end else if (wr) begin
      if (idx_w == IDX_EN_DSEL) en_reg <= pwdata[7:4];
      if (idx_w == IDX_DCNT) brg_reg <= pwdata[F_BRIDGE];
      if (idx_w == IDX_SPEED) spd_reg <= pwdata[1:0];
      if (idx_w == IDX_MASK) mask_reg <= pwdata[4:0];
      if (idx_w == IDX_SRC_SEL) src_reg <= pwdata[2];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_reg <= 16'h0000;
    else if (en_reg != 4'h0) quiet_reg <= 16'h0000;
    else if (quiet_reg != 16'hFFFF) quiet_reg <= quiet_reg + 16'h0001;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  access_ready_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  map_error_a: assert property (psel && penable |-> pslverr == !map_ok)
    else $error("error flag does not match the register map");
  upper_zero_a: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("read data above bit 7 not zero");
  disabled_quiet_a: assert property (
    en_reg == 4'h0 && !brg_reg && spd_reg == 2'h0 && int'(quiet_reg) > QUIET |-> !link_oe)
    else $error("wire driven with every agent disabled");
  bit_start_a: assert property ($rose(link_oe) |-> link_out)
    else $error("wire taken without a high start slot");
  irq_masked_a: assert property (mask_reg == 5'h00 |-> !irq)
    else $error("interrupt with everything masked");
  bridge_follow_a: assert property (
    brg_reg && int'(quiet_reg) > QUIET && secondary_link_pin_in && !link_in &&
    !secondary_link_pin_oe |-> ##[1:3] (link_oe && link_out))
    else $error("bridge did not pass a high level to the client wire");
  half_clear_a: assert property (!first_temp_reading[0] && !second_temp_reading[0])
    else $error("half-degree bit set");
  unsel_zero_a: assert property (
    !src_reg && !$past(src_reg) |-> first_temp_reading == 9'h000)
    else $error("unselected source gives a nonzero reading");
endmodule // poller_checker

bind thermal_one_wire_poller poller_checker #(.QTR_SLOW_CYC(QTR_SLOW_CYC)) u_poller_checker (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .link_in, .link_out, .link_oe, .secondary_link_pin_in, .secondary_link_pin_out,
  .secondary_link_pin_oe, .first_temp_reading, .second_temp_reading, .irq);

// [dts_client_model.sv]
// behavioural thermal sensor client on the single wire
// assumes a pull-down on the wire and quarter slots of Q clock cycles
`timescale 1ns/1ps
module dts_client_model #(
  parameter int Q = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_out,
  input wire logic link_oe,
  input wire logic link_in,
  input wire logic [15:0] rel0,
  input wire logic [15:0] rel1,
  input wire logic [3:0] bad,
  output logic drv,
  output logic [15:0] frames
);
  logic [5:0] bits_reg;
  logic [15:0] cnt_reg, rel;
  logic [31:0] wr_reg, wr_next;
  logic [23:0] rd_reg;
  logic hi_reg;
  assign wr_next = {wr_reg[30:0], link_in};
  assign rel = wr_next[8] ? rel1 : rel0;
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // answer bits sit in slots 1 and 2 so a host lag of a cycle still samples them
  assign drv = bits_reg > 6'd32 && cnt_reg > 16'(Q) && cnt_reg <= 16'(3 * Q) && rd_reg[23];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bits_reg <= 6'd0;
      cnt_reg <= 16'h0000;
      wr_reg <= 32'h0000_0000;
      rd_reg <= 24'h000000;
      hi_reg <= 1'b0;
      frames <= 16'h0000;
    end else begin
      hi_reg <= link_oe & link_out;
      if (link_oe && link_out && !hi_reg) begin
        bits_reg <= bits_reg + 6'd1;
        cnt_reg <= 16'h0000;
        if (bits_reg > 6'd32) rd_reg <= {rd_reg[22:0], 1'b0};
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
        if (cnt_reg == 16'(6 * Q)) bits_reg <= 6'd0;
      end
      if (cnt_reg == 16'(2 * Q) && bits_reg <= 6'd32) wr_reg <= wr_next;
      if (cnt_reg == 16'(2 * Q) && bits_reg == 6'd32) begin
        rd_reg <= {rel[7:0], rel[15:8], crc8({rel[7:0], rel[15:8]}) ^ {7'h00, bad[wr_next[25:24]]}};
      end
      if (cnt_reg == 16'(4 * Q) && bits_reg == 6'd56) frames <= frames + 16'h0001;
    end
  end
endmodule // dts_client_model

// [thermal_one_wire_poller_tb.sv]
// self-checking bench for the thermal single-wire poller
// assumes the client model and the checker are compiled before it
`timescale 1ns/1ps
module thermal_one_wire_poller_tb;
  import poller_pkg::*;
  localparam int Q = 4;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} exp_t;
  exp_t exp_q[$];
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, seed = 32'h0000_17F6;
  logic pready, pslverr, link_in, link_out, link_oe, sec_in, sec_out, sec_oe, irq, drv;
  logic sec_drv = 1'b0, link_ext = 1'b0;
  logic [8:0] rd1, rd2;
  logic [15:0] r0 = 16'h0000, r1 = 16'h0000, frames, v, w;
  logic [3:0] bad = 4'h0;
  logic [7:0] base [4];
  int n_errors = 0, compares = 0, cyc = 0;
  // released wires fall to the pull-down level
  assign link_in = link_oe ? link_out : (drv | link_ext);
  assign sec_in = sec_oe ? sec_out : sec_drv;
  initial forever #2.5 pclk = ~pclk;
  thermal_one_wire_poller #(.QTR_SLOW_CYC(Q)) u_thermal_one_wire_poller (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .link_in, .link_out, .link_oe, .secondary_link_pin_in(sec_in),
    .secondary_link_pin_out(sec_out), .secondary_link_pin_oe(sec_oe),
    .first_temp_reading(rd1), .second_temp_reading(rd2), .irq);
  dts_client_model #(.Q(Q)) u_dts_client_model (.clk(pclk), .rst_n(presetn), .link_out,
    .link_oe, .link_in, .rel0(r0), .rel1(r1), .bad, .drv, .frames);
  task automatic stop_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      stop_test();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] tmp(input int a, input logic [15:0] r);
    return base[a] + 8'($signed(r) >>> 6);
  endfunction
  task automatic chk_bus(input exp_t x);
    compares++;
    if ((prdata & x.m) !== (x.d & x.m) || pslverr !== x.e) begin
      n_errors++;
      $display("[FAIL] %0t bus %h err %b want %h", $time, prdata, pslverr, x.d);
    end
  endtask
  task automatic chk_pin(input logic [8:0] got, input logic [8:0] want);
    compares++;
    if (got !== want) begin
      n_errors++;
      $display("[FAIL] %0t pin %h want %h", $time, got, want);
    end
  endtask
  always @(posedge pclk) if (psel && penable && pready) chk_bus(exp_q.pop_front());
  // writes note only the error flag; reads note data under a mask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     input logic [7:0] m, input logic e);
    exp_q.push_back('{32'(d), 32'(m), e});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= 32'(d);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] idx, d);
    apb(1'b1, idx, d, 8'h00, 1'b0);
  endtask
  task automatic rd(input logic [7:0] idx, d, m);
    apb(1'b0, idx, d, m, 1'b0);
  endtask
  task automatic frames_wait(input int k);
    int f0;
    f0 = int'(frames);
    while (int'(frames) < f0 + k) @(posedge pclk);
    repeat (8) @(posedge pclk);
  endtask
  task automatic quiet_wait();
    int n;
    n = 0;
    while (n < 64 * Q) begin
      @(posedge pclk);
      n = link_oe ? 0 : n + 1;
    end
  endtask
  task automatic temps(input logic [7:0] e1, input logic [7:0] e2);
    chk_pin(rd1, {e1, 1'b0});
    chk_pin(rd2, {e2, 1'b0});
    rd(IDX_RD1_HI, e1, 8'hFF);
    rd(IDX_RD1_LO, 8'h00, 8'h80);
    rd(IDX_RD2_HI, e2, 8'hFF);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(IDX_EN_DSEL, 8'h00, 8'hF0);
    apb(1'b0, 8'h10, 8'h00, 8'hFF, 1'b1);
    apb(1'b1, 8'h10, 8'h5A, 8'h00, 1'b1);
    wr(IDX_SPEED, 8'h00);
    for (int i = 0; i < 4; i++) begin
      base[i] = 8'(rnd() % 90 + 10);
      wr(IDX_BASE1 + 8'(i), base[i]);
      rd(IDX_BASE1 + 8'(i), base[i], 8'hFF);
    end
    v = 16'(-int'(rnd() % 2560));
    w = v + 16'(64 * (1 + rnd() % 8));
    r0 <= v;
    r1 <= w;
    wr(IDX_SRC_SEL, 8'h54);
    wr(IDX_DCNT, 8'h00);
    wr(IDX_EN_DSEL, 8'h30);
    frames_wait(8);
    temps(tmp(0, v), tmp(1, v));
    rd(IDX_RAW_LO, v[7:0], 8'hFF);
    rd(IDX_RAW_HI, v[15:8], 8'hFF);
    wr(IDX_DCNT, 8'h10);
    wr(IDX_EN_DSEL, 8'h31);
    frames_wait(10);
    temps(tmp(0, w), tmp(1, v));
    wr(IDX_DCNT, 8'h32);
    wr(IDX_EN_DSEL, 8'h30);
    frames_wait(12);
    temps(tmp(0, w), tmp(1, w));
    wr(IDX_EN_DSEL, 8'h00);
    quiet_wait();
    wr(IDX_DCNT, 8'h00);
    rd(IDX_STATUS, 8'h10, 8'h1F);
    wr(IDX_MASK, 8'h01);
    bad <= 4'h1;
    wr(IDX_EN_DSEL, 8'h10);
    frames_wait(2);
    rd(IDX_SPEED, 8'h00, 8'hF0);
    chk_pin(9'(irq), 9'h000);
    frames_wait(1);
    rd(IDX_SPEED, 8'h10, 8'hF0);
    chk_pin(9'(irq), 9'h001);
    rd(IDX_STATUS, 8'h01, 8'h1F);
    chk_pin(9'(irq), 9'h000);
    bad <= 4'h0;
    frames_wait(2);
    rd(IDX_SPEED, 8'h00, 8'hF0);
    wr(IDX_MASK, 8'h10);
    chk_pin(9'(irq), 9'h001);
    wr(IDX_MASK, 8'h00);
    chk_pin(9'(irq), 9'h000);
    wr(IDX_EN_DSEL, 8'h00);
    quiet_wait();
    wr(IDX_DCNT, 8'h01);
    sec_drv <= 1'b1;
    for (int n = 0; n < 8 && link_in !== 1'b1; n++) @(posedge pclk);
    chk_pin(9'(link_oe & link_out), 9'h001);
    sec_drv <= 1'b0;
    for (int n = 0; n < 8 && link_oe !== 1'b0; n++) @(posedge pclk);
    chk_pin(9'(link_oe), 9'h000);
    link_ext <= 1'b1;
    for (int n = 0; n < 8 && sec_in !== 1'b1; n++) @(posedge pclk);
    chk_pin(9'(sec_oe & sec_out), 9'h001);
    stop_test();
  end
endmodule // thermal_one_wire_poller_tb
